// [hw/bfm_monitor.sv]
// converter fault supervision: power good, current detectors, short circuit, foldback
//
// Summary of operation
// - power-good flag reads 0 while output is below its power-good threshold.
// - unmasked power-good loss drives the active-low interrupt low.
// - interrupt holds until converter off or back in regulation, and flag read.
// - turn-on shift bit delays high-side turn-on about 110 ns after clock edge.
// - edge-alignment bit picks rising or falling switching clock edge for turn-on.
// - peak current threshold comes from the programmable limit setting field.
// - peak current at threshold turns the power switch off for that cycle.
// - 75 % threshold for 16 consecutive cycles sets warning and interrupt, keeps running.
// - full threshold for 16 consecutive cycles drives the interrupt low.
// - 122.5 % peak shuts the supply down at once; interrupt unless masked.
// - after a masked short-circuit shutdown the supply restarts 14 ms later.
// - unmasked short enters supply-fault state, all supplies off, restart after 100 ms.
// - after soft-start, out of regulation over 28 us folds the limit to 1.5 A.
// - regaining regulation under foldback restarts output and restores default limit.
// - overcurrent and short events latch in status bits until read.
// - current fault mask suppresses overcurrent and short interrupts and the short system fault.
`timescale 1ns/1ns
module bfm_monitor
	import bfm_pkg::*;
#(
	parameter int SC_CYC  = SC_RESTART_CYC,	// local restart delay in mclk cycles
	parameter int SYS_CYC = SYS_RESTART_CYC	// system restart delay in mclk cycles
) (
	input  wire logic               mclk,	// 50 MHz system clock
	input  wire logic               resetn,	// async reset, active low
	input  wire logic               converter_on,	// converter enable from host
	input  wire logic               fault_unmask_bit,	// 1: power-good loss interrupts
	input  wire logic               current_fault_mask,	// 1: current faults masked
	input  wire logic [LIMIT_W-1:0] peak_limit_setting,	// peak current limit code
	input  wire logic               slow_freq,	// 1: 1.125 MHz switching
	input  wire logic               phase_delay_en,	// turn-on shift enable
	input  wire logic               phase_falling,	// turn-on on falling edge
	input  wire logic               below_pg_pin,	// comparator: output under threshold
	input  wire logic               peak_warn_pin,	// comparator: peak at 75 % limit
	input  wire logic               peak_full_pin,	// comparator: peak at limit
	input  wire logic               peak_short_pin,	// comparator: peak at 122.5 % limit
	input  wire logic               soft_start_done_pin,	// analog soft-start finished
	input  wire logic               read_power_good,	// pulse: host read the flag
	input  wire logic               read_limit_status,	// pulse: host read current status
	output logic                    power_good_flag,	// 1: output in regulation
	output logic                    interrupt_request_n,	// interrupt, active low
	output logic                    near_limit_warning,	// latched near-limit warning
	output logic [1:0]              current_limit_status,	// latched overcurrent, short
	output logic                    supply_fault_state,	// system fault, all supplies off
	output logic                    supply_enable,	// converter may switch
	output logic                    hs_gate,	// high-side switch drive
	output logic                    foldback_active,	// limit reduced to 1.5 A
	output logic                    restart_soft_start,	// pulse: start a new soft-start
	output logic [LIMIT_W-1:0]      thr_warn,	// 75 % comparator code
	output logic [LIMIT_W-1:0]      thr_full,	// full limit comparator code
	output logic [LIMIT_W:0]        thr_short	// 122.5 % comparator code
);
	localparam int TW = $clog2(SYS_CYC + 1);
	localparam int FW = $clog2(FOLD_CYC + 2);
	localparam int KW = $clog2(CONSEC_CYCLES + 1);

	initial begin
		if (SC_CYC < 1 || SYS_CYC < SC_CYC)
			$error("restart delays out of range");
	end

	function automatic logic [LIMIT_W:0] scale(input logic [LIMIT_W-1:0] v,
			input int num, input int den);
		int prod;
		prod = int'(v) * num / den;
		return (LIMIT_W+1)'(prod);
	endfunction

	bfm_sw_if sw ();

	bfm_phase_gen u_phase (
		.mclk           (mclk),
		.resetn         (resetn),
		.slow_freq      (slow_freq),
		.phase_delay_en (phase_delay_en),
		.phase_falling  (phase_falling),
		.sw             (sw.gen)
	);

	logic [PIN_COUNT-1:0] pin_meta;
	logic [PIN_COUNT-1:0] pin_s;
	logic below_s, warn_s, full_s, short_s, ss_done_s;

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			pin_meta <= '0;
			pin_s    <= '0;
		end else begin
			pin_meta <= {soft_start_done_pin, peak_short_pin, peak_full_pin,
				peak_warn_pin, below_pg_pin};
			pin_s    <= pin_meta;
		end
	end
	assign below_s   = pin_s[PIN_BELOW_PG];
	assign warn_s    = pin_s[PIN_PEAK_WARN];
	assign full_s    = pin_s[PIN_PEAK_FULL];
	assign short_s   = pin_s[PIN_PEAK_SHORT];
	assign ss_done_s = pin_s[PIN_SS_DONE];

	// comparator references follow the host's setting
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			thr_warn  <= '0;
			thr_full  <= '0;
			thr_short <= '0;
		end else begin
			thr_full  <= peak_limit_setting;
			thr_warn  <= LIMIT_W'(scale(peak_limit_setting, WARN_NUM, WARN_DEN));
			thr_short <= scale(peak_limit_setting, SHORT_NUM, SHORT_DEN);
		end
	end

	bfm_state_e    state;
	logic [TW-1:0] timer;
	logic          short_event;
	assign short_event = (state == ST_RUN) && converter_on && short_s;

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			state <= ST_RUN;
			timer <= '0;
		end else begin
			case (state)
				ST_RUN: begin
					timer <= '0;
					if (short_event)
						state <= current_fault_mask ? ST_LOCAL_OFF : ST_SYS_FAULT;
				end
				ST_LOCAL_OFF: begin
					timer <= timer + TW'(1);
					if (timer == TW'(SC_CYC - 1))
						state <= ST_RUN;
				end
				ST_SYS_FAULT: begin
					timer <= timer + TW'(1);
					if (timer == TW'(SYS_CYC - 1))
						state <= ST_RUN;
				end
				default: state <= ST_RUN;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			supply_enable      <= 1'b0;
			supply_fault_state <= 1'b0;
		end else begin
			supply_enable      <= converter_on && state == ST_RUN && !short_event;
			supply_fault_state <= state == ST_SYS_FAULT;
		end
	end

	// per-cycle peak detection; a hit anywhere in the cycle counts for that cycle
	logic          seen_warn, seen_full;
	logic          warn_hit, full_hit;
	logic [KW-1:0] warn_cnt, full_cnt;
	logic          limit_event;
	assign warn_hit    = seen_warn || warn_s;
	assign full_hit    = seen_full || full_s;
	assign limit_event = sw.cycle_start && full_hit && full_cnt == KW'(CONSEC_CYCLES - 1);

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			seen_warn <= 1'b0;
			seen_full <= 1'b0;
			warn_cnt  <= '0;
			full_cnt  <= '0;
		end else if (sw.cycle_start) begin
			seen_warn <= 1'b0;
			seen_full <= 1'b0;
			warn_cnt  <= !warn_hit ? '0 : (warn_cnt == KW'(CONSEC_CYCLES)) ?
				warn_cnt : warn_cnt + KW'(1);
			full_cnt  <= !full_hit ? '0 : (full_cnt == KW'(CONSEC_CYCLES)) ?
				full_cnt : full_cnt + KW'(1);
		end else begin
			seen_warn <= warn_hit;
			seen_full <= full_hit;
		end
	end

	// high side opens at the phase point and closes on peak limit for the rest of the cycle
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn)
			hs_gate <= 1'b0;
		else if (full_s || !supply_enable || sw.cycle_start)
			hs_gate <= 1'b0;
		else if (sw.hs_on && !seen_full)
			hs_gate <= 1'b1;
	end
	// status and warning latch until read; a new event in the read cycle wins
	logic warn_set;
	assign warn_set = sw.cycle_start && warn_hit && warn_cnt == KW'(CONSEC_CYCLES - 1);

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			near_limit_warning   <= 1'b0;
			current_limit_status <= '0;
		end else begin
			near_limit_warning <= warn_set || (near_limit_warning && !read_limit_status);
			current_limit_status[STAT_OVERCURRENT] <= limit_event ||
				(current_limit_status[STAT_OVERCURRENT] && !read_limit_status);
			current_limit_status[STAT_SHORT] <= short_event ||
				(current_limit_status[STAT_SHORT] && !read_limit_status);
		end
	end
	// interrupt sources
	logic pg_irq, pg_read_done, limit_irq, short_irq;

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			pg_irq       <= 1'b0;
			pg_read_done <= 1'b0;
		end else if (fault_unmask_bit && converter_on && below_s) begin
			pg_irq       <= 1'b1;
			pg_read_done <= pg_read_done || (pg_irq && read_power_good);
		end else if (pg_irq && pg_read_done) begin
			pg_irq       <= 1'b0;
			pg_read_done <= 1'b0;
		end else begin
			pg_read_done <= pg_irq && (pg_read_done || read_power_good);
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			limit_irq <= 1'b0;
			short_irq <= 1'b0;
		end else begin
			limit_irq <= (limit_event && !current_fault_mask) ||
				(limit_irq && !read_limit_status);
			short_irq <= (short_event && !current_fault_mask) ||
				(short_irq && !read_limit_status);
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			interrupt_request_n <= 1'b1;
			power_good_flag     <= 1'b0;
		end else begin
			interrupt_request_n <= !(pg_irq || near_limit_warning || limit_irq || short_irq);
			power_good_flag     <= !below_s;
		end
	end
	// foldback to FOLD_LIMIT_MA after a long loss of regulation
	logic [FW-1:0] fold_cnt;
	logic          fold_arm;
	assign fold_arm = ss_done_s && below_s && supply_enable && !foldback_active;

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			fold_cnt           <= '0;
			foldback_active    <= 1'b0;
			restart_soft_start <= 1'b0;
		end else begin
			restart_soft_start <= 1'b0;
			if (!fold_arm)
				fold_cnt <= '0;
			else if (fold_cnt == FW'(FOLD_CYC)) begin
				foldback_active <= 1'b1;
				fold_cnt        <= '0;
			end else
				fold_cnt <= fold_cnt + FW'(1);
			if (foldback_active && !below_s) begin
				foldback_active    <= 1'b0;
				restart_soft_start <= 1'b1;
			end
			if ((state == ST_LOCAL_OFF && timer == TW'(SC_CYC - 1)) ||
					(state == ST_SYS_FAULT && timer == TW'(SYS_CYC - 1)))
				restart_soft_start <= 1'b1;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);
	property p_pg_low;
		below_s |=> !power_good_flag;
	endproperty
	a_pg_low: assert property (p_pg_low) else $error("power good flag high");
	property p_pg_irq;
		fault_unmask_bit && converter_on && below_s |=> ##1 !interrupt_request_n;
	endproperty
	a_pg_irq: assert property (p_pg_irq) else $error("power good loss not raised");
	property p_pg_hold;
		pg_irq && !pg_read_done && !read_power_good |=> pg_irq;
	endproperty
	a_pg_hold: assert property (p_pg_hold) else $error("power good irq dropped unread");
	property p_fet_off;
		full_s |=> !hs_gate;
	endproperty
	a_fet_off: assert property (p_fet_off) else $error("switch on after peak limit");
	property p_warn;
		warn_set |=> near_limit_warning ##1 !interrupt_request_n;
	endproperty
	a_warn: assert property (p_warn) else $error("near limit warning missing");
	property p_limit_irq;
		limit_event && !current_fault_mask |=> ##1 !interrupt_request_n;
	endproperty
	a_limit_irq: assert property (p_limit_irq) else $error("limit irq missing");
	property p_short_off;
		short_event |=> !supply_enable [*3];
	endproperty
	a_short_off: assert property (p_short_off) else $error("supply on after short");
	property p_local_restart;
		state == ST_LOCAL_OFF && timer == TW'(SC_CYC - 1) |=> state == ST_RUN && restart_soft_start;
	endproperty
	a_local_restart: assert property (p_local_restart) else $error("local restart missed");
	property p_sys_fault;
		short_event && !current_fault_mask |=> ##1 supply_fault_state && !supply_enable;
	endproperty
	a_sys_fault: assert property (p_sys_fault) else $error("no supply fault state");
	property p_fold;
		fold_arm && fold_cnt == FW'(FOLD_CYC) |=> foldback_active;
	endproperty
	a_fold: assert property (p_fold) else $error("foldback not applied");
	property p_unfold;
		foldback_active && !below_s |=> !foldback_active && restart_soft_start;
	endproperty
	a_unfold: assert property (p_unfold) else $error("foldback not released");
	property p_status_hold;
		current_limit_status[STAT_SHORT] && !read_limit_status |=>
			current_limit_status[STAT_SHORT];
	endproperty
	a_status_hold: assert property (p_status_hold) else $error("short status lost");
	property p_mask;
		current_fault_mask && !short_irq && !read_limit_status |=> !short_irq;
	endproperty
	a_mask: assert property (p_mask) else $error("masked short raised irq");
	property p_cnt_clear;
		sw.cycle_start && !full_hit |=> full_cnt == '0;
	endproperty
	a_cnt_clear: assert property (p_cnt_clear) else $error("counter not cleared");
endmodule

// [hw/bfm_pkg.sv]
// constants shared by the converter fault monitor and its switching phase generator
package bfm_pkg;
	localparam int CLK_HZ          = 50_000_000;
	localparam int CLK_PER_US      = CLK_HZ / 1_000_000;
	localparam int CLK_PER_MS      = CLK_HZ / 1_000;
	// switching clock periods, rounded down to whole mclk cycles
	localparam int FSW_FAST_HZ     = 2_250_000;
	localparam int FSW_SLOW_HZ     = 1_125_000;
	localparam int PERIOD_FAST_CYC = CLK_HZ / FSW_FAST_HZ;
	localparam int PERIOD_SLOW_CYC = CLK_HZ / FSW_SLOW_HZ;
	// high-side turn-on shift, rounded up
	localparam int PHASE_SHIFT_NS  = 110;
	localparam int PHASE_SHIFT_CYC = (PHASE_SHIFT_NS * CLK_PER_US + 999) / 1000;
	// foldback after the output stays out of regulation longer than this
	localparam int FOLD_US         = 28;
	localparam int FOLD_CYC        = FOLD_US * CLK_PER_US;
	localparam int SC_RESTART_MS   = 14;
	localparam int SC_RESTART_CYC  = SC_RESTART_MS * CLK_PER_MS;
	localparam int SYS_RESTART_MS  = 100;
	localparam int SYS_RESTART_CYC = SYS_RESTART_MS * CLK_PER_MS;
	localparam int CONSEC_CYCLES   = 16;
	// comparator thresholds as fractions of the limit setting: 75 % and 122.5 %
	localparam int WARN_NUM        = 3;
	localparam int WARN_DEN        = 4;
	localparam int SHORT_NUM       = 49;
	localparam int SHORT_DEN       = 40;
	localparam int LIMIT_W         = 8;
	localparam int FOLD_LIMIT_MA   = 1500;
	// current_limit_status bit positions
	localparam int STAT_OVERCURRENT = 0;
	localparam int STAT_SHORT       = 1;
	// synchroniser lanes
	localparam int PIN_BELOW_PG    = 0;
	localparam int PIN_PEAK_WARN   = 1;
	localparam int PIN_PEAK_FULL   = 2;
	localparam int PIN_PEAK_SHORT  = 3;
	localparam int PIN_SS_DONE     = 4;
	localparam int PIN_COUNT       = 5;

	typedef enum logic [1:0] {
		ST_RUN,
		ST_LOCAL_OFF,
		ST_SYS_FAULT
	} bfm_state_e;
endpackage

// [hw/bfm_sw_if.sv]
// switching-cycle timing carried from the phase generator to the fault monitor
`timescale 1ns/1ns
interface bfm_sw_if;
	logic cycle_start;	// one-cycle pulse at the master switching clock rising edge
	logic hs_on;	// one-cycle pulse: high-side switch may turn on
	modport gen (output cycle_start, output hs_on);
	modport mon (input cycle_start, input hs_on);
endinterface

// [hw/bfm_phase_gen.sv]
// master switching clock divider and high-side turn-on phase placement
`timescale 1ns/1ns
module bfm_phase_gen
	import bfm_pkg::*;
(
	input  wire logic mclk,	// system clock
	input  wire logic resetn,	// async reset, active low
	input  wire logic slow_freq,	// 1: 1.125 MHz switching, 0: 2.25 MHz
	input  wire logic phase_delay_en,	// shift turn-on after the chosen edge
	input  wire logic phase_falling,	// align turn-on to the falling edge
	bfm_sw_if.gen     sw	// timing pulses out
);
	localparam int CW = $clog2(PERIOD_SLOW_CYC);

	initial begin
		if (PERIOD_FAST_CYC / 2 + PHASE_SHIFT_CYC >= PERIOD_FAST_CYC)
			$error("phase shift does not fit in the switching period");
	end

	logic [CW-1:0] cnt;
	logic          cfg_slow;
	logic          cfg_delay;
	logic          cfg_fall;
	logic [CW-1:0] period_m1;
	logic [CW-1:0] turn_on_at;

	// configuration is taken only at a cycle boundary so a change never splits a period
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			cfg_slow  <= 1'b0;
			cfg_delay <= 1'b0;
			cfg_fall  <= 1'b0;
		end else if (cnt == period_m1) begin
			cfg_slow  <= slow_freq;
			cfg_delay <= phase_delay_en;
			cfg_fall  <= phase_falling;
		end
	end

	always_comb begin
		period_m1  = cfg_slow ? CW'(PERIOD_SLOW_CYC - 1) : CW'(PERIOD_FAST_CYC - 1);
		turn_on_at = cfg_fall ? CW'((period_m1 + CW'(1)) >> 1) : '0;
		if (cfg_delay)
			turn_on_at = turn_on_at + CW'(PHASE_SHIFT_CYC);
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn)
			cnt <= '0;
		else if (cnt == period_m1)
			cnt <= '0;
		else
			cnt <= cnt + CW'(1);
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			sw.cycle_start <= 1'b0;
			sw.hs_on       <= 1'b0;
		end else begin
			sw.cycle_start <= (cnt == period_m1);
			sw.hs_on       <= (cnt == turn_on_at);
		end
	end

	property p_shift_rising;
		@(posedge mclk) disable iff (!resetn)
		sw.hs_on && cfg_delay && !cfg_fall && $stable(cfg_slow) |->
			$past(sw.cycle_start, PHASE_SHIFT_CYC + 1);
	endproperty
	a_shift_rising: assert property (p_shift_rising)
		else $error("delayed turn-on not placed after the rising edge");

	property p_align_rising;
		@(posedge mclk) disable iff (!resetn)
		sw.cycle_start && !cfg_delay && !cfg_fall |=> sw.hs_on;
	endproperty
	a_align_rising: assert property (p_align_rising)
		else $error("undelayed turn-on not aligned to the rising edge");
endmodule

// [testbench/bfm_host_model.sv]
// host side model: turns bench requests into one-cycle status read pulses
`timescale 1ns/1ns
module bfm_host_model (
	input  wire logic mclk,	// system clock
	output logic      read_power_good,	// pulse: flag read
	output logic      read_limit_status	// pulse: current status read
);
	initial begin
		read_power_good   = 1'b0;
		read_limit_status = 1'b0;
	end
	// called just after a rising edge; the pulse covers exactly one edge
	task automatic read_pg();
		read_power_good <= 1'b1;
		@(posedge mclk);
		read_power_good <= 1'b0;
	endtask
	task automatic read_stat();
		read_limit_status <= 1'b1;
		@(posedge mclk);
		read_limit_status <= 1'b0;
	endtask
endmodule

// [testbench/tb_top.sv]
// self-checking bench for the converter fault monitor
`timescale 1ns/1ns
module tb_top;
	import bfm_pkg::*;
	// short restart delays keep the run brief
	localparam int SC  = 20;
	localparam int SYS = 40;
	logic               mclk, resetn, converter_on, fault_unmask_bit, current_fault_mask;
	logic [LIMIT_W-1:0] peak_limit_setting, thr_warn, thr_full;
	logic [LIMIT_W:0]   thr_short;
	logic               slow_freq, phase_delay_en, phase_falling, below_pg_pin;
	logic               peak_warn_pin, peak_full_pin, peak_short_pin, soft_start_done_pin;
	logic               read_power_good, read_limit_status, power_good_flag;
	logic               interrupt_request_n, near_limit_warning, supply_fault_state;
	logic               supply_enable, hs_gate, foldback_active, restart_soft_start, chop;
	logic               full_force;
	logic [1:0]         current_limit_status;
	int                 n_errors, samples_checked, n, t0, t1;
	int                 tick = 0;

	bfm_monitor #(.SC_CYC(SC), .SYS_CYC(SYS)) i_dut (.mclk, .resetn, .converter_on,
		.fault_unmask_bit, .current_fault_mask, .peak_limit_setting, .slow_freq,
		.phase_delay_en, .phase_falling, .below_pg_pin, .peak_warn_pin, .peak_full_pin,
		.peak_short_pin, .soft_start_done_pin, .read_power_good, .read_limit_status,
		.power_good_flag, .interrupt_request_n, .near_limit_warning, .current_limit_status,
		.supply_fault_state, .supply_enable, .hs_gate, .foldback_active,
		.restart_soft_start, .thr_warn, .thr_full, .thr_short);
	bfm_host_model i_host (.mclk, .read_power_good, .read_limit_status);

	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	always @(posedge mclk) tick <= tick + 1;
	// chopper: the peak comparator fires while the gate is on, so the gate pulses each period
	always @(posedge mclk) peak_full_pin <= chop ? hs_gate : full_force;

	task automatic chk(string nm, logic [8:0] got, logic [8:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic step(int k);
		repeat (k) @(posedge mclk);
	endtask
	task automatic at(int k);
		repeat (k) @(posedge mclk);
		@(negedge mclk);
	endtask
	function automatic logic sel(int k);
		case (k)
			0: return restart_soft_start;
			1: return foldback_active;
			default: return hs_gate;
		endcase
	endfunction
	task automatic wait_v(int k, logic v, int lim, output int c);
		c = 0;
		while (sel(k) !== v && c < lim) begin
			@(negedge mclk);
			c++;
		end
	endtask
	task automatic rise(output int t);
		int c;
		wait_v(2, 1'b0, 60, c);
		wait_v(2, 1'b1, 60, c);
		t = tick;
	endtask
	task automatic done(string s);
		$display("test %s finished", s);
	endtask
	task automatic finish_test();
		$display("checks %0d errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge mclk);
		n_errors++;
		finish_test();
	end

	initial begin
		{resetn, converter_on, fault_unmask_bit, current_fault_mask, slow_freq} = '0;
		{phase_delay_en, phase_falling, below_pg_pin, peak_warn_pin} = '0;
		{full_force, peak_short_pin, soft_start_done_pin, chop} = '0;
		peak_limit_setting = 8'h80;
		n_errors = 0;
		samples_checked = 0;
		at(9);
		chk("irq_in_reset", interrupt_request_n, 1'b1);
		step(1);
		resetn <= 1'b1;
		converter_on <= 1'b1;
		at(3);
		chk("thr_warn", thr_warn, 8'h60);
		chk("thr_full", thr_full, 8'h80);
		chk("thr_short", thr_short, 9'h09C);
		chk("pg_flag", power_good_flag, 1'b1);
		step(1);
		peak_limit_setting <= 8'hFF;
		at(2);
		chk("thr_warn", thr_warn, 8'hBF);
		chk("thr_short", thr_short, 9'h138);
		done("thresholds");

		step(1);
		fault_unmask_bit <= 1'b1;
		below_pg_pin <= 1'b1;
		at(5);
		chk("pg_flag", power_good_flag, 1'b0);
		chk("irq_pg", interrupt_request_n, 1'b0);
		step(1);
		below_pg_pin <= 1'b0;
		at(8);
		chk("irq_unread", interrupt_request_n, 1'b0);
		chk("pg_flag", power_good_flag, 1'b1);
		step(1);
		i_host.read_pg();
		at(4);
		chk("irq_read", interrupt_request_n, 1'b1);
		step(1);
		fault_unmask_bit <= 1'b0;
		below_pg_pin <= 1'b1;
		at(8);
		chk("irq_masked", interrupt_request_n, 1'b1);
		step(1);
		below_pg_pin <= 1'b0;
		done("power_good");

		peak_warn_pin <= 1'b1;
		step(13 * 22);
		peak_warn_pin <= 1'b0;
		step(66);
		peak_warn_pin <= 1'b1;
		at(13 * 22);
		chk("warn_early", near_limit_warning, 1'b0);
		at(18 * 22);
		chk("warn", near_limit_warning, 1'b1);
		chk("irq_warn", interrupt_request_n, 1'b0);
		chk("still_on", supply_enable, 1'b1);
		step(1);
		peak_warn_pin <= 1'b0;
		i_host.read_stat();
		at(4);
		chk("warn_read", near_limit_warning, 1'b0);
		chk("irq_free", interrupt_request_n, 1'b1);
		done("warning");

		step(1);
		chop <= 1'b1;
		rise(t0);
		wait_v(2, 1'b0, 10, n);
		chk("gate_cut", n <= 5, 1'b1);
		rise(t1);
		chk("period", 9'(t1 - t0), 9'h016);
		step(1);
		phase_delay_en <= 1'b1;
		step(50);
		rise(t1);
		chk("shift", 9'((t1 - t0) % 22), 9'h006);
		step(1);
		phase_delay_en <= 1'b0;
		phase_falling <= 1'b1;
		step(50);
		rise(t1);
		chk("falling", 9'((t1 - t0) % 22), 9'h00B);
		step(1);
		phase_falling <= 1'b0;
		slow_freq <= 1'b1;
		step(100);
		rise(t0);
		rise(t1);
		chk("slow_period", 9'(t1 - t0), 9'h02C);
		step(1);
		chop <= 1'b0;
		slow_freq <= 1'b0;
		// the chopper ran fewer than 16 periods and latched no overcurrent; let the counter clear, then read status
		step(88);
		i_host.read_stat();
		full_force <= 1'b1;
		at(20 * 22);
		chk("limit_stat", current_limit_status, 2'b01);
		chk("irq_limit", interrupt_request_n, 1'b0);
		chk("gate_held_off", hs_gate, 1'b0);
		step(1);
		full_force <= 1'b0;
		at(50);
		chk("stat_kept", current_limit_status, 2'b01);
		step(1);
		i_host.read_stat();
		at(4);
		chk("stat_read", current_limit_status, 2'b00);
		chk("irq_free", interrupt_request_n, 1'b1);
		done("limit");

		step(1);
		current_fault_mask <= 1'b1;
		peak_short_pin <= 1'b1;
		step(2);
		peak_short_pin <= 1'b0;
		at(2);
		chk("short_off", supply_enable, 1'b0);
		chk("short_stat", current_limit_status, 2'b10);
		chk("irq_masked", interrupt_request_n, 1'b1);
		chk("no_sys", supply_fault_state, 1'b0);
		wait_v(0, 1'b1, SC + 20, n);
		chk("local_delay", n >= SC - 4 && n <= SC + 2, 1'b1);
		at(3);
		chk("back_on", supply_enable, 1'b1);
		step(1);
		i_host.read_stat();
		current_fault_mask <= 1'b0;
		peak_short_pin <= 1'b1;
		step(2);
		peak_short_pin <= 1'b0;
		at(3);
		chk("sys_fault", supply_fault_state, 1'b1);
		chk("all_off", supply_enable, 1'b0);
		chk("irq_short", interrupt_request_n, 1'b0);
		wait_v(0, 1'b1, SYS + 20, n);
		chk("sys_delay", n >= SYS - 6 && n <= SYS + 2, 1'b1);
		at(3);
		chk("sys_left", supply_fault_state, 1'b0);
		step(1);
		i_host.read_stat();
		at(3);
		chk("irq_free", interrupt_request_n, 1'b1);
		done("short");

		step(1);
		below_pg_pin <= 1'b1;
		at(1500);
		chk("no_fold_ss", foldback_active, 1'b0);
		step(1);
		soft_start_done_pin <= 1'b1;
		at(1385);
		chk("fold_early", foldback_active, 1'b0);
		wait_v(1, 1'b1, 40, n);
		chk("fold_on", foldback_active, 1'b1);
		step(1);
		below_pg_pin <= 1'b0;
		wait_v(0, 1'b1, 8, n);
		chk("fold_restart", n < 8, 1'b1);
		chk("fold_off", foldback_active, 1'b0);
		done("foldback");
		finish_test();
	end
endmodule
